// ==== src/ucr_pkg.sv ====
// Shared constants and types for the UART register control block
package ucr_pkg;
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_ISR_FCR = 3'h2;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_RX_TIMEOUT = 6'h0C;
   localparam logic [5:0] SRC_RX_READY = 6'h04;
   localparam logic [5:0] SRC_TX_READY = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_CHAR_MATCH = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   localparam int FIFO_EN_BIT = 0;
   localparam int RX_RST_BIT = 1;
   localparam int TX_RST_BIT = 2;
   localparam int WAKE_EN_BIT = 3;
   localparam logic [1:0] TBL_A = 2'b00;
   localparam logic [1:0] TBL_B = 2'b01;
   localparam logic [1:0] TBL_C = 2'b10;
   localparam logic [1:0] TBL_D = 2'b11;

   // Decoded line format for transmitter and receiver
   typedef struct packed {
      logic [3:0] word_bits;
      logic stop_long;
      logic stop_half;
      logic parity_en;
      logic parity_forced;
      logic parity_even;
      logic parity_force_val;
   } ucr_format_s;

   // Trigger levels for both directions
   typedef struct packed {
      logic [7:0] rx_level;
      logic [7:0] tx_level;
   } ucr_trig_s;
endpackage

// ==== src/ucr_ctrl.sv ====
// UART register control: interrupt status, FIFO control and line format
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Bit 0 low means interrupt pending
// R2: Bits 3:1 give prioritized source code
// R3: Highest priority source code in bits 5:0
// R4: Status read or data write clears transmit-ready
// R5: Bit 4 flags character match when enhanced
// R6: Bit 5 flags flow control rising when enhanced
// R7: Bit 7 mirrors FIFO enable
// R8: Bit 6 inverts bit 7 on GPIO interrupt
// R9: FIFO control bit 0 gates other bits
// R10: Bit 1 clears receive FIFO, self-clears
// R11: Bit 2 clears transmit FIFO, self-clears
// R12: Bit 3 enables wake-up when enhanced
// R13: Transmit interrupt below level or empty
// R14: Receive interrupt when count crosses level
// R15: Both directions share last selected table
// R16: Tables A and B trigger levels
// R17: Tables C and D trigger levels
// R18: Line bits 1:0 set word length
// R19: Line bit 2 sets stop length
// R20: Line bit 3 enables parity
// R21: Line bit 4 selects odd or even
// R22: Line bit 5 forces parity value
module ucr_ctrl #(
   parameter int FIFO_DEPTH = 128
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input wire logic enhanced_en,
   input wire logic [1:0] table_sel,
   input wire logic trig_dir_tx,
   input wire logic [7:0] trig_prog,
   input wire logic [7:0] rx_count,
   input wire logic [7:0] tx_count,
   input wire logic tx_reload,
   input wire logic line_irq,
   input wire logic rx_timeout_irq,
   input wire logic modem_irq,
   input wire logic char_match,
   input wire logic cts_in_n,
   input wire logic rts_out_n,
   input wire logic wake_event,
   input wire logic gpio_irq_en,
   input wire logic gpio_irq,
   output logic fifo_en,
   output logic rx_fifo_clr,
   output logic tx_fifo_clr,
   output logic wake_irq_en,
   output logic [7:0] rx_trig,
   output logic [7:0] tx_trig,
   output ucr_pkg::ucr_format_s line_fmt
);
   logic [7:0] line_format_control;
   logic [7:0] next_lcr;
   logic [1:0] rx_sel;
   logic [1:0] next_rx_sel;
   logic [1:0] tx_sel;
   logic [1:0] next_tx_sel;
   logic [7:0] trg_rx;
   logic [7:0] next_trg_rx;
   logic [7:0] trg_tx;
   logic [7:0] next_trg_tx;
   logic next_fifo_en;
   logic next_rx_fifo_clr;
   logic next_tx_fifo_clr;
   logic next_wake_irq_en;
   logic tx_ready;
   logic next_tx_ready;
   logic tx_above;
   logic next_tx_above;
   logic rx_ready;
   logic next_rx_ready;
   logic match_flag;
   logic next_match_flag;
   logic flow_flag;
   logic next_flow_flag;
   logic wake_flag;
   logic next_wake_flag;
   logic cts_s1;
   logic cts_s2;
   logic cts_prev;
   logic rts_prev;
   logic [7:0] next_rd_data;
   logic [5:0] src;
   logic [7:0] interrupt_source_status;
   ucr_pkg::ucr_trig_s trig;
   ucr_pkg::ucr_format_s next_fmt;
   logic isr_rd;
   logic thr_wr;
   logic fcr_wr;

   assign isr_rd = rd_stb && addr == ucr_pkg::ADDR_ISR_FCR;
   assign thr_wr = wr_stb && addr == ucr_pkg::ADDR_DATA && !line_format_control[7];
   assign fcr_wr = wr_stb && addr == ucr_pkg::ADDR_ISR_FCR;

   // Trigger table decode, shared by both directions
   always_comb begin
      trig = '0;
      case (table_sel) // R15
         ucr_pkg::TBL_A: begin // R16
            case (rx_sel)
               2'b00: trig.rx_level = 8'h01;
               2'b01: trig.rx_level = 8'h04;
               2'b10: trig.rx_level = 8'h08;
               default: trig.rx_level = 8'h0E;
            endcase
            trig.tx_level = 8'h01;
         end
         ucr_pkg::TBL_B: begin // R16
            case (rx_sel)
               2'b00: trig.rx_level = 8'h08;
               2'b01: trig.rx_level = 8'h10;
               2'b10: trig.rx_level = 8'h18;
               default: trig.rx_level = 8'h1C;
            endcase
            case (tx_sel)
               2'b00: trig.tx_level = 8'h10;
               2'b01: trig.tx_level = 8'h08;
               2'b10: trig.tx_level = 8'h18;
               default: trig.tx_level = 8'h1E;
            endcase
         end
         ucr_pkg::TBL_C: begin // R17
            case (rx_sel)
               2'b00: trig.rx_level = 8'h08;
               2'b01: trig.rx_level = 8'h10;
               2'b10: trig.rx_level = 8'h38;
               default: trig.rx_level = 8'h3C;
            endcase
            case (tx_sel)
               2'b00: trig.tx_level = 8'h08;
               2'b01: trig.tx_level = 8'h10;
               2'b10: trig.tx_level = 8'h20;
               default: trig.tx_level = 8'h38;
            endcase
         end
         default: begin // R17
            trig.rx_level = trg_rx;
            trig.tx_level = trg_tx;
         end
      endcase
   end

   // Highest priority pending source
   always_comb begin
      if (line_irq) begin // R3
         src = ucr_pkg::SRC_LINE;
      end else if (rx_timeout_irq) begin
         src = ucr_pkg::SRC_RX_TIMEOUT;
      end else if (rx_ready) begin
         src = ucr_pkg::SRC_RX_READY;
      end else if (tx_ready) begin
         src = ucr_pkg::SRC_TX_READY;
      end else if (modem_irq) begin
         src = ucr_pkg::SRC_MODEM;
      end else if (match_flag) begin // R5
         src = ucr_pkg::SRC_CHAR_MATCH;
      end else if (flow_flag) begin // R6
         src = ucr_pkg::SRC_FLOW;
      end else begin
         src = ucr_pkg::SRC_NONE; // R1
      end
      interrupt_source_status[5:0] = src; // R2
      interrupt_source_status[7] = fifo_en; // R7
      interrupt_source_status[6] = (gpio_irq_en && gpio_irq) ? !fifo_en : fifo_en; // R8
   end

   // Register and interrupt flag next values
   always_comb begin
      next_lcr = line_format_control;
      next_fifo_en = fifo_en;
      next_rx_fifo_clr = 1'b0; // R10
      next_tx_fifo_clr = 1'b0; // R11
      next_wake_irq_en = wake_irq_en;
      next_rx_sel = rx_sel;
      next_tx_sel = tx_sel;
      next_trg_rx = trg_rx;
      next_trg_tx = trg_tx;
      next_rd_data = rd_data;
      if (wr_stb && addr == ucr_pkg::ADDR_LCR) begin
         next_lcr = wr_data;
      end else if (fcr_wr) begin
         next_fifo_en = wr_data[ucr_pkg::FIFO_EN_BIT];
         if (wr_data[ucr_pkg::FIFO_EN_BIT]) begin // R9
            next_rx_fifo_clr = wr_data[ucr_pkg::RX_RST_BIT]; // R10
            next_tx_fifo_clr = wr_data[ucr_pkg::TX_RST_BIT]; // R11
            next_rx_sel = wr_data[7:6];
            // Wake enable and transmit selection are ignored unless enhanced
            if (enhanced_en) begin
               next_wake_irq_en = wr_data[ucr_pkg::WAKE_EN_BIT]; // R12
               next_tx_sel = wr_data[5:4];
            end
         end
      end
      if (table_sel == ucr_pkg::TBL_D && wr_stb && addr == ucr_pkg::ADDR_DATA && line_format_control[7]) begin
         if (trig_dir_tx) begin // R17
            next_trg_tx = wr_data;
         end else begin
            next_trg_rx = wr_data;
         end
      end
      if (rd_stb) begin
         if (addr == ucr_pkg::ADDR_ISR_FCR) begin
            next_rd_data = interrupt_source_status;
         end else if (addr == ucr_pkg::ADDR_LCR) begin
            next_rd_data = line_format_control;
         end else begin
            next_rd_data = 8'h00;
         end
      end
      // Set wins over clear on every flag except tx_ready, where a status read or data write wins over set
      next_tx_above = tx_above;
      if (tx_reload && tx_count >= trig.tx_level) begin
         next_tx_above = 1'b1;
      end else if (tx_count == 8'h00) begin
         next_tx_above = 1'b0;
      end
      next_tx_ready = tx_ready && !(isr_rd || thr_wr); // R4
      if (fifo_en && (tx_count < trig.tx_level || (tx_count == 8'h00 && !tx_above))) begin
         if (!(tx_ready || isr_rd || thr_wr)) begin
            next_tx_ready = 1'b1; // R13
         end
      end
      next_rx_ready = fifo_en && rx_count >= trig.rx_level; // R14
      next_match_flag = (match_flag && !isr_rd) || (enhanced_en && char_match); // R5
      next_flow_flag = (flow_flag && !isr_rd) ||
         (enhanced_en && ((cts_s2 && !cts_prev) || (rts_out_n && !rts_prev))); // R6
      next_wake_flag = (wake_flag && !isr_rd) || (wake_irq_en && enhanced_en && wake_event); // R12
      next_fmt.word_bits = 4'h5 + {2'b00, line_format_control[1:0]}; // R18
      next_fmt.stop_long = line_format_control[2]; // R19
      next_fmt.stop_half = line_format_control[2] && line_format_control[1:0] == 2'b00; // R19
      next_fmt.parity_en = line_format_control[3]; // R20
      next_fmt.parity_even = line_format_control[4]; // R21
      next_fmt.parity_forced = line_format_control[5]; // R22
      next_fmt.parity_force_val = !line_format_control[4]; // R22
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         line_format_control <= ucr_pkg::LCR_RESET;
         fifo_en <= 1'b0;
         rx_fifo_clr <= 1'b0;
         tx_fifo_clr <= 1'b0;
         wake_irq_en <= 1'b0;
         rx_sel <= 2'b00;
         tx_sel <= 2'b00;
         trg_rx <= 8'h00;
         trg_tx <= 8'h00;
         rd_data <= 8'h00;
         tx_ready <= 1'b0;
         tx_above <= 1'b0;
         rx_ready <= 1'b0;
         match_flag <= 1'b0;
         flow_flag <= 1'b0;
         wake_flag <= 1'b0;
         // Idle level of the active-low pins, so no false edge after reset
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
         cts_prev <= 1'b1;
         rts_prev <= 1'b1;
         rx_trig <= 8'h00;
         tx_trig <= 8'h00;
         line_fmt <= '0;
      end else begin
         line_format_control <= next_lcr;
         fifo_en <= next_fifo_en;
         rx_fifo_clr <= next_rx_fifo_clr;
         tx_fifo_clr <= next_tx_fifo_clr;
         wake_irq_en <= next_wake_irq_en;
         rx_sel <= next_rx_sel;
         tx_sel <= next_tx_sel;
         trg_rx <= next_trg_rx;
         trg_tx <= next_trg_tx;
         rd_data <= next_rd_data;
         tx_ready <= next_tx_ready;
         tx_above <= next_tx_above;
         rx_ready <= next_rx_ready;
         match_flag <= next_match_flag;
         flow_flag <= next_flow_flag;
         wake_flag <= next_wake_flag;
         cts_s1 <= cts_in_n;
         cts_s2 <= cts_s1;
         cts_prev <= cts_s2;
         rts_prev <= rts_out_n;
         rx_trig <= trig.rx_level;
         tx_trig <= trig.tx_level;
         line_fmt <= next_fmt;
      end
   end
endmodule // ucr_ctrl
`default_nettype wire

// ==== testbench/ucr_host.sv ====
// Host processor model for the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module ucr_host (
   input wire logic ref_clk,
   input wire logic [7:0] rd_data,
   output logic [2:0] addr,
   output logic rd_stb,
   output logic wr_stb,
   output logic [7:0] wr_data
);
   initial begin
      {addr, rd_stb, wr_stb, wr_data} = 13'h0000;
   end
   // One-cycle write strobe; data is scrambled once the strobe drops
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wr_data = d;
      wr_stb = 1'h1;
      @(negedge ref_clk);
      wr_stb = 1'h0;
      wr_data = ~d;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      rd_stb = 1'h1;
      @(negedge ref_clk);
      rd_stb = 1'h0;
      d = rd_data;
   endtask
endmodule // ucr_host
`default_nettype wire

// ==== testbench/ucr_ctrl_sva.sv ====
// Port assertions for the UART register control block
`timescale 1ns/1ps
`default_nettype none
module ucr_ctrl_sva #(
   parameter int FIFO_DEPTH = 128
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic enhanced_en,
   input wire logic line_irq,
   input wire logic gpio_irq_en,
   input wire logic gpio_irq,
   input wire logic fifo_en,
   input wire logic rx_fifo_clr,
   input wire logic tx_fifo_clr,
   input wire logic wake_irq_en,
   input wire ucr_pkg::ucr_format_s line_fmt
);
   logic fw, lw, sr, rc, gi;
   assign fw = wr_stb && addr == ucr_pkg::ADDR_ISR_FCR;
   assign lw = wr_stb && addr == ucr_pkg::ADDR_LCR;
   assign sr = rd_stb && addr == ucr_pkg::ADDR_ISR_FCR;
   assign rc = fw && wr_data[0] && wr_data[1];
   assign gi = gpio_irq_en && gpio_irq;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_en; fw |=> fifo_en == $past(wr_data[0]); endproperty
   a_en: assert property (p_en) else $error("fifo_en");
   property p_ign; fw && !wr_data[0] |=> !rx_fifo_clr && !tx_fifo_clr; endproperty
   a_ign: assert property (p_ign) else $error("ignored");
   property p_rc; rc |=> rx_fifo_clr; endproperty
   a_rc: assert property (p_rc) else $error("rx clr");
   property p_rcp; rx_fifo_clr |-> $past(rc); endproperty
   a_rcp: assert property (p_rcp) else $error("rx clr cause");
   property p_tc; fw && wr_data[0] && wr_data[2] |=> tx_fifo_clr; endproperty
   a_tc: assert property (p_tc) else $error("tx clr");
   property p_wk; fw && wr_data[0] && enhanced_en |=> wake_irq_en == $past(wr_data[3]); endproperty
   a_wk: assert property (p_wk) else $error("wake");
   property p_b7; sr |=> rd_data[7] == $past(fifo_en); endproperty
   a_b7: assert property (p_b7) else $error("bit7");
   property p_b6; sr |=> rd_data[6] == ($past(fifo_en) ^ $past(gi)); endproperty
   a_b6: assert property (p_b6) else $error("bit6");
   property p_ln; sr && line_irq |=> rd_data[5:0] == ucr_pkg::SRC_LINE; endproperty
   a_ln: assert property (p_ln) else $error("line code");
   property p_wl; lw |=> ##1 line_fmt.word_bits == 4'h5 + $past(wr_data[1:0], 2); endproperty
   a_wl: assert property (p_wl) else $error("word");
   property p_pe; lw |=> ##1 line_fmt.parity_en == $past(wr_data[3], 2); endproperty
   a_pe: assert property (p_pe) else $error("parity");
endmodule // ucr_ctrl_sva
bind ucr_ctrl ucr_ctrl_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_sva (.ref_clk(ref_clk), .rst(rst),
   .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data),
   .enhanced_en(enhanced_en), .line_irq(line_irq), .gpio_irq_en(gpio_irq_en),
   .gpio_irq(gpio_irq), .fifo_en(fifo_en), .rx_fifo_clr(rx_fifo_clr),
   .tx_fifo_clr(tx_fifo_clr), .wake_irq_en(wake_irq_en), .line_fmt(line_fmt));
`default_nettype wire

// ==== testbench/test_uart_irq_status_fifo_ctrl_line_format.sv ====
// Self-checking bench for the UART register control block
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module test_uart_irq_status_fifo_ctrl_line_format;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic en, line, rxto, modem, cm, rts, gen, girq, rd_stb, wr_stb, fen, rclr, tclr, wen;
   logic tdir = 1'h0;
   logic [1:0] ts;
   logic [2:0] addr;
   logic [7:0] rxc, txc, q, rd_data, wr_data, rxt, txt;
   ucr_pkg::ucr_format_s fmt;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   ucr_host i_host (.ref_clk(ref_clk), .rd_data(rd_data), .addr(addr), .rd_stb(rd_stb),
      .wr_stb(wr_stb), .wr_data(wr_data));
   ucr_ctrl #(.FIFO_DEPTH(128)) i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data),
      .enhanced_en(en), .table_sel(ts), .trig_dir_tx(tdir), .trig_prog(8'h00),
      .rx_count(rxc), .tx_count(txc), .tx_reload(1'h0), .line_irq(line),
      .rx_timeout_irq(rxto), .modem_irq(modem), .char_match(cm), .cts_in_n(1'h0),
      .rts_out_n(rts), .wake_event(1'h0), .gpio_irq_en(gen), .gpio_irq(girq),
      .fifo_en(fen), .rx_fifo_clr(rclr), .tx_fifo_clr(tclr), .wake_irq_en(wen),
      .rx_trig(rxt), .tx_trig(txt), .line_fmt(fmt));
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic st(input logic [7:0] e);
      i_host.rd(ucr_pkg::ADDR_ISR_FCR, q);
      `CK("status", e, q)
   endtask
   task automatic t_fcr;
      st(8'h01);
      `CK("word_bits", 4'h5, fmt.word_bits)
      i_host.wr(ucr_pkg::ADDR_ISR_FCR, 8'h06);
      `CK("rclr", 1'h0, rclr)
      i_host.wr(ucr_pkg::ADDR_ISR_FCR, 8'h07);
      `CK("rclr", 1'h1, rclr)
      `CK("tclr", 1'h1, tclr)
      @(negedge ref_clk);
      `CK("rclr", 1'h0, rclr)
      en = 1'h1;
      i_host.wr(ucr_pkg::ADDR_ISR_FCR, 8'h09);
      en = 1'h0;
      i_host.wr(ucr_pkg::ADDR_ISR_FCR, 8'h01);
      `CK("wen", 1'h1, wen)
      en = 1'h1;
      $display("t_fcr done");
   endtask
   task automatic t_trig;
      logic [7:0] rl [12] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h08, 8'h10, 8'h18, 8'h1C,
         8'h08, 8'h10, 8'h38, 8'h3C};
      logic [7:0] tl [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08, 8'h18, 8'h1E,
         8'h08, 8'h10, 8'h20, 8'h38};
      for (int i = 0; i < 12; i++) begin
         ts = 2'(i / 4);
         i_host.wr(ucr_pkg::ADDR_ISR_FCR, {2'(i), 2'(i), 4'h1});
         @(negedge ref_clk);
         `CK("rx_trig", rl[i], rxt)
         `CK("tx_trig", tl[i], txt)
      end
      // Programmable table: levels written through the data address
      i_host.wr(ucr_pkg::ADDR_LCR, 8'h80);
      ts = 2'h3;
      tdir = 1'h0;
      i_host.wr(ucr_pkg::ADDR_DATA, 8'h2A);
      tdir = 1'h1;
      i_host.wr(ucr_pkg::ADDR_DATA, 8'h33);
      @(negedge ref_clk);
      `CK("rx_trig", 8'h2A, rxt)
      `CK("tx_trig", 8'h33, txt)
      i_host.wr(ucr_pkg::ADDR_LCR, 8'h00);
      ts = 2'h0;
      i_host.wr(ucr_pkg::ADDR_ISR_FCR, 8'hC1);
      $display("t_trig done");
   endtask
   task automatic t_lcr;
      for (int i = 0; i < 4; i++) begin
         i_host.wr(ucr_pkg::ADDR_LCR, {2'h0, 2'(i), 2'h2, 2'(i)});
         i_host.rd(ucr_pkg::ADDR_LCR, q);
         `CK("lcr", {2'h0, 2'(i), 2'h2, 2'(i)}, q)
         `CK("word_bits", 4'(5 + i), fmt.word_bits)
         `CK("parity_en", 1'h1, fmt.parity_en)
         `CK("forced", i[1], fmt.parity_forced)
         if (i[1]) `CK("force_val", ~i[0], fmt.parity_force_val)
         else `CK("even", i[0], fmt.parity_even)
      end
      $display("t_lcr done");
   endtask
   task automatic t_flags;
      cm = 1'h1;
      @(negedge ref_clk);
      cm = 1'h0;
      st(8'hD0);
      rts = 1'h1;
      repeat (3) @(negedge ref_clk);
      st(8'hE0);
      st(8'hC1);
      {gen, girq} = 2'h3;
      st(8'h81);
      gen = 1'h0;
      st(8'hC1);
      $display("t_flags done");
   endtask
   task automatic t_status;
      {line, rxto, modem} = 3'h7;
      rxc = 8'h14;
      st(8'hC6);
      line = 1'h0;
      st(8'hCC);
      rxto = 1'h0;
      st(8'hC4);
      rxc = 8'h0D;
      st(8'hC0);
      modem = 1'h0;
      st(8'hC1);
      txc = 8'h00;
      st(8'hC2);
      txc = 8'h64;
      st(8'hC1);
      $display("t_status done");
   endtask
   initial begin
      {en, line, rxto, modem, cm, rts, gen, girq} = 8'h00;
      ts = 2'h0;
      rxc = 8'h00;
      txc = 8'h64;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'h0;
      t_fcr;
      t_trig;
      t_lcr;
      t_flags;
      t_status;
      end_of_test;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 2000) begin
         bad_count++;
         end_of_test;
      end
   end
endmodule // test_uart_irq_status_fifo_ctrl_line_format
`default_nettype wire
